// ### rtl/sfc_pkg.sv
// constants and types shared by the sample buffer flag, tag and crc block
package sfc_pkg;
  localparam int DEPTH = 256;
  localparam logic [8:0] FULL = 9'h100;
  localparam logic [7:0] FLAGS_OFS = 8'h3B;
  localparam logic [7:0] CTRL_OFS = 8'h3A;
  localparam logic [23:0] CTRL_RST = 24'h040200;
  localparam logic [7:0] FLAGS_RST = 8'h01;
  localparam logic [7:0] TAG_RST = 8'h00;
  localparam logic [7:0] RD_CMD = 8'h7D;
  localparam logic [15:0] CRC_POLY = 16'hA2EB;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  // control word fields
  localparam int CTRL_WM_LSB = 0;
  localparam int CTRL_IE_LSB = 8;
  localparam int CTRL_MODE_LSB = 16;
  localparam int CTRL_HDR = 18;
  localparam int CTRL_STAT = 19;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_WM = 2'h1;
  localparam logic [1:0] MODE_STREAM = 2'h2;
  // status byte fields
  localparam int FL_EMPTY = 0;
  localparam int FL_WM = 1;
  localparam int FL_OVR = 2;
  localparam int FL_LO = 3;
  localparam int FL_HI = 4;
  localparam int FL_RERR = 5;
  localparam int FL_WERR = 6;
  localparam int FL_CERR = 7;
  // tag byte fields
  localparam int TAG_EMPTY = 4;
  localparam int TAG_WM = 5;
  localparam int TAG_THR = 6;
  // serial bit counts, as first or last index of each unit
  localparam logic [4:0] STAT_FIRST = 5'h07;
  localparam logic [4:0] CNT_FIRST = 5'h08;
  localparam logic [4:0] CMD_LAST = 5'h0E;
  localparam logic [4:0] LEN_TAG = 5'h17;
  localparam logic [4:0] LEN_RAW = 5'h0F;
  localparam logic [4:0] CRC_LAST = 5'h0F;
  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_DATA = 2'b01,
    PH_CRC = 2'b10,
    PH_IDLE = 2'b11
  } sfc_phase_t;
endpackage : sfc_pkg

// ### rtl/sfc_core.sv
// sample buffer status, tag, crc and interrupt logic with serial readback
// Summary of operation
// [RULE1] while enabled, a busy/available level is shown on busy_o
// [RULE2] watermark mode: busy until count reaches watermark; streaming: busy on each write
// [RULE3] tag byte: input index bits 3:0, empty 4, watermark 5, threshold 6, bit 7 zero
// [RULE4] tag stored with every result; omitted from readback when tag append is off
// [RULE5] tag of the last stored sample read out carries the empty bit
// [RULE6] tag watermark bit set when stored with occupancy at or above watermark
// [RULE7] tag threshold bit: input limit enable set and result outside limits, per sample
// [RULE8] status append shifts the status byte out during the sample-count byte
// [RULE9] empty flag sets on draining read or empty read, clears on write, resets 1
// [RULE10] watermark flag follows occupancy at or above watermark setting
// [RULE11] overrun sets on lost result, clears when drained by read or cleared
// [RULE12] upper and lower limit flags are sticky until drained or cleared
// [RULE13] read during a write sets read error and returns zero data and tag
// [RULE14] write waits one conversion for a readback, then is dropped with write error
// [RULE15] watermark mode write at watermark occupancy sets write error, not stored
// [RULE16] status bit 7 mirrors the controller error bit
// [RULE17] crc only with status append off and tag on, after each watermark block
// [RULE18] first crc covers command, count byte and data; later ones only data
// [RULE19] crc generator 0xA2EB, start value all ones
// [RULE20] interrupt is the or of all enabled flag sources
// [RULE21] watermark interrupt enabled after reset; watermark field 0 means 256
// [RULE22] watermark interrupt high while occupancy at or above trigger count
// [RULE23] host reads with command 0x7D then a count byte, 0 meaning 256
// [RULE24] samples take 24 clocks with tag, 16 without; command takes 16
// [RULE25] control write while enabled clears contents and clearable flags
// [RULE26] crc runs msb first over sent bits and is shifted out msb first
`timescale 1ns/1ps
module sfc_core (
  // master clock domain
  input wire logic clk_i,
  input wire logic arst_n_i,
  // configuration from the register map
  input wire logic [23:0] ctrl_i,
  input wire logic ctrl_wr_i,
  input wire logic ctrl_err_i,
  input wire logic crc_en_i,
  input wire logic [15:0] per_input_limit_enable_i,
  input wire logic [15:0] upper_limit_value_i,
  input wire logic [15:0] lower_limit_value_i,
  // conversion engine
  input wire logic conv_valid_i,
  input wire logic [15:0] conv_data_i,
  input wire logic [3:0] source_input_index_i,
  // serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  // status
  output logic busy_o,
  output logic [7:0] buffer_condition_flags_o,
  output logic fifo_int_o
);

  typedef struct packed {
    logic [sfc_pkg::DEPTH-1:0][23:0] mem;
    logic [7:0] head;
    logic [8:0] cnt;
    logic pend;
    logic [15:0] pdat;
    logic [3:0] pch;
    logic [7:0] fl;
    logic cs1;
    logic cs2;
    logic lock;
    logic refused;
    logic [8:0] pg1;
    logic [8:0] pg2;
    logic [8:0] pseen;
    logic busy;
    logic irq;
  } sfc_core_t;

  typedef struct packed {
    sfc_pkg::sfc_phase_t phase;
    logic [4:0] bc;
    logic fst;
    logic [7:0] cmd;
    logic [7:0] cntb;
    logic [8:0] idx;
    logic [8:0] blk;
    logic [15:0] crc;
    logic [23:0] sh;
    logic sdo;
    logic rf1;
    logic rf2;
    logic [7:0] st1;
    logic [7:0] st2;
  } sfc_frame_t;

  typedef struct packed {
    logic [8:0] pb;
    logic [8:0] pg;
  } sfc_pop_t;

  function automatic logic [15:0] sfc_crc_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = b ^ c[15];
    return {c[14:0], 1'b0} ^ (fb ? sfc_pkg::CRC_POLY : 16'h0000);
  endfunction : sfc_crc_step

  function automatic logic [8:0] sfc_g2b(input logic [8:0] g);
    logic [8:0] b;
    b[8] = g[8];
    for (int i = 7; i >= 0; i--)
    begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : sfc_g2b

  sfc_core_t s_reg;
  sfc_core_t s_next;
  sfc_frame_t f_reg;
  sfc_frame_t f_next;
  sfc_pop_t p_reg;
  sfc_pop_t p_next;
  logic [8:0] trig;
  logic [1:0] mode;
  logic en;
  logic rise;
  logic store;
  logic [8:0] pdelta;
  logic pop;
  logic frm_rst_n;

  // ---------------- master clock domain ----------------
  always_comb
  begin
    logic [7:0] wa;
    logic hi;
    logic lo;
    logic [7:0] tag;
    s_next = s_reg;
    wa = 8'h00;
    hi = 1'b0;
    lo = 1'b0;
    tag = sfc_pkg::TAG_RST;
    store = 1'b0;
    mode = ctrl_i[sfc_pkg::CTRL_MODE_LSB +: 2];
    en = mode != sfc_pkg::MODE_OFF;
    // a field value of zero stands for the full depth
    trig = (ctrl_i[sfc_pkg::CTRL_WM_LSB +: 8] == 8'h00) ? sfc_pkg::FULL
         : {1'b0, ctrl_i[sfc_pkg::CTRL_WM_LSB +: 8]}; // RULE21
    s_next.cs1 = ~cs_n_i;
    s_next.cs2 = s_reg.cs1;
    s_next.lock = s_reg.cs2;
    rise = s_reg.cs2 & ~s_reg.lock;
    s_next.pg1 = p_reg.pg;
    s_next.pg2 = s_reg.pg1;
    pdelta = sfc_g2b(s_reg.pg2) - s_reg.pseen;
    s_next.fl[sfc_pkg::FL_CERR] = ctrl_err_i; // RULE16
    // consumed samples are retired only while the link is idle, so the
    // link side sees head, count and storage frozen during a frame
    if (!s_reg.lock)
    begin
      s_next.pseen = sfc_g2b(s_reg.pg2);
      if (pdelta != 9'h000)
      begin
        s_next.head = s_reg.head + pdelta[7:0];
        s_next.cnt = s_reg.cnt - pdelta;
        if (s_next.cnt == 9'h000)
        begin
          s_next.fl[sfc_pkg::FL_EMPTY] = 1'b1; // RULE9
          s_next.fl[sfc_pkg::FL_OVR] = 1'b0; // RULE11
          s_next.fl[sfc_pkg::FL_HI] = 1'b0; // RULE12
          s_next.fl[sfc_pkg::FL_LO] = 1'b0; // RULE12
          s_next.fl[sfc_pkg::FL_WERR] = 1'b0; // RULE14
          s_next.fl[sfc_pkg::FL_RERR] = 1'b0; // RULE13
        end
      end
    end
    // start of a frame: refuse it if the converter is writing right now
    if (rise)
    begin
      s_next.refused = conv_valid_i;
      s_next.fl[sfc_pkg::FL_RERR] = conv_valid_i; // RULE13
      if (s_next.cnt == 9'h000 && !conv_valid_i)
      begin
        s_next.fl[sfc_pkg::FL_EMPTY] = 1'b1; // RULE9
      end
    end
    if (conv_valid_i)
    begin
      // a result still waiting from the previous conversion is lost
      if (s_reg.pend)
      begin
        s_next.fl[sfc_pkg::FL_WERR] = 1'b1; // RULE14
      end
      s_next.pend = 1'b1;
      s_next.pdat = conv_data_i;
      s_next.pch = source_input_index_i;
    end
    if (!s_reg.lock && s_next.pend) // RULE14
    begin
      s_next.pend = 1'b0;
      if (en && mode == sfc_pkg::MODE_WM && s_next.cnt >= trig)
      begin
        s_next.fl[sfc_pkg::FL_WERR] = 1'b1; // RULE15
        s_next.fl[sfc_pkg::FL_OVR] = 1'b1; // RULE11
      end
      else if (en)
      begin
        store = 1'b1;
        wa = s_next.head + s_next.cnt[7:0];
        if (s_next.cnt == sfc_pkg::FULL)
        begin
          // streaming: the oldest entry is overwritten
          s_next.head = s_next.head + 8'h01;
          s_next.fl[sfc_pkg::FL_OVR] = 1'b1; // RULE11
        end
        else
        begin
          s_next.cnt = s_next.cnt + 9'h001;
        end
        hi = s_next.pdat > upper_limit_value_i;
        lo = s_next.pdat < lower_limit_value_i;
        tag[3:0] = s_next.pch; // RULE3
        tag[sfc_pkg::TAG_WM] = s_next.cnt >= trig; // RULE6
        tag[sfc_pkg::TAG_THR] = per_input_limit_enable_i[s_next.pch] & (hi | lo); // RULE7
        s_next.mem[wa] = {s_next.pdat, tag}; // RULE4
        s_next.fl[sfc_pkg::FL_HI] = s_next.fl[sfc_pkg::FL_HI] | hi; // RULE12
        s_next.fl[sfc_pkg::FL_LO] = s_next.fl[sfc_pkg::FL_LO] | lo; // RULE12
        s_next.fl[sfc_pkg::FL_EMPTY] = 1'b0; // RULE9
      end
    end
    if (ctrl_wr_i && en)
    begin
      s_next.cnt = 9'h000; // RULE25
      s_next.pend = 1'b0;
      s_next.fl[6:0] = sfc_pkg::FLAGS_RST[6:0]; // RULE25
    end
    s_next.fl[sfc_pkg::FL_WM] = s_next.cnt >= trig; // RULE10
    s_next.busy = en & ((mode == sfc_pkg::MODE_WM) ? (s_next.cnt < trig) : store); // RULE1 RULE2
    s_next.irq = |(s_next.fl[6:0] & ctrl_i[sfc_pkg::CTRL_IE_LSB +: 7]); // RULE20 RULE22
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_reg <= '0;
      s_reg.fl <= sfc_pkg::FLAGS_RST; // RULE9
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign busy_o = s_reg.busy;
  assign buffer_condition_flags_o = s_reg.fl;
  assign fifo_int_o = s_reg.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_int;
    fifo_int_o == |(s_reg.fl[6:0] & $past(ctrl_i[14:8]));
  endproperty
  a_int: assert property (p_int) else $error("interrupt is not the enabled or"); // RULE20

  property p_wm;
    buffer_condition_flags_o[sfc_pkg::FL_WM] == (s_reg.cnt >= $past(trig));
  endproperty
  a_wm: assert property (p_wm) else $error("watermark flag wrong"); // RULE10

  property p_busy;
    ($past(en) && $past(mode) == sfc_pkg::MODE_WM) |-> busy_o == (s_reg.cnt < $past(trig));
  endproperty
  a_busy: assert property (p_busy) else $error("busy level wrong in watermark mode"); // RULE2

  property p_empty_clr;
    (store && !ctrl_wr_i) |=> !buffer_condition_flags_o[sfc_pkg::FL_EMPTY] ##1 1'b1;
  endproperty
  a_empty_clr: assert property (p_empty_clr) else $error("empty flag kept after write"); // RULE9

  property p_clr;
    (ctrl_wr_i && en) |=> (s_reg.cnt == 9'h000 && buffer_condition_flags_o[6:0] == 7'h01);
  endproperty
  a_clr: assert property (p_clr) else $error("control write did not clear"); // RULE25

  property p_ovr;
    (conv_valid_i && !s_reg.lock && !s_reg.pend && en && mode == sfc_pkg::MODE_STREAM
      && s_reg.cnt == sfc_pkg::FULL && pdelta == 9'h000 && !ctrl_wr_i)
      |=> buffer_condition_flags_o[sfc_pkg::FL_OVR] && s_reg.cnt == sfc_pkg::FULL;
  endproperty
  a_ovr: assert property (p_ovr) else $error("streaming overrun not flagged"); // RULE11

  property p_werr;
    (conv_valid_i && !s_reg.lock && en && mode == sfc_pkg::MODE_WM && s_reg.cnt >= trig
      && pdelta == 9'h000 && !ctrl_wr_i)
      |=> buffer_condition_flags_o[sfc_pkg::FL_WERR] && $stable(s_reg.cnt);
  endproperty
  a_werr: assert property (p_werr) else $error("write at watermark not refused"); // RULE15

  property p_thr;
    (buffer_condition_flags_o[sfc_pkg::FL_HI] && !ctrl_wr_i
      && (s_reg.lock || s_reg.cnt != pdelta)) |=> buffer_condition_flags_o[sfc_pkg::FL_HI];
  endproperty
  a_thr: assert property (p_thr) else $error("upper limit flag not sticky"); // RULE12

  property p_rderr;
    (rise && conv_valid_i) |=> (buffer_condition_flags_o[sfc_pkg::FL_RERR] && s_reg.refused);
  endproperty
  a_rderr: assert property (p_rderr) else $error("read during write not flagged"); // RULE13

  property p_pend;
    (conv_valid_i && s_reg.pend && !ctrl_wr_i) |=> buffer_condition_flags_o[sfc_pkg::FL_WERR];
  endproperty
  a_pend: assert property (p_pend) else $error("second pending write not flagged"); // RULE14

  // ---------------- link clock domain ----------------
  // frame state is cleared by the select line itself, since the link
  // clock stops between frames; storage and settings are read as
  // quasi-static values while the master side holds them frozen
  assign frm_rst_n = arst_n_i & ~cs_n_i;

  always_comb
  begin
    logic [23:0] cur;
    logic [23:0] wd;
    logic [7:0] ia;
    logic [15:0] cr;
    logic [4:0] len;
    logic [8:0] nsmp;
    logic hdr;
    logic crc_on;
    f_next = f_reg;
    pop = 1'b0;
    cur = f_reg.sh;
    cr = f_reg.crc;
    hdr = ctrl_i[sfc_pkg::CTRL_HDR];
    crc_on = crc_en_i & ~ctrl_i[sfc_pkg::CTRL_STAT] & hdr; // RULE17
    len = hdr ? sfc_pkg::LEN_TAG : sfc_pkg::LEN_RAW; // RULE24
    nsmp = (f_reg.cntb == 8'h00) ? sfc_pkg::FULL : {1'b0, f_reg.cntb}; // RULE23
    ia = s_reg.head + f_reg.idx[7:0];
    wd = 24'h000000;
    if (!f_reg.rf2) // RULE13
    begin
      if (f_reg.idx < s_reg.cnt)
      begin
        wd = s_reg.mem[ia];
      end
      if ((f_reg.idx + 9'h001) >= s_reg.cnt)
      begin
        wd[sfc_pkg::TAG_EMPTY] = 1'b1; // RULE5
      end
    end
    if (!hdr)
    begin
      wd[7:0] = 8'h00; // RULE4
    end
    f_next.rf1 = s_reg.refused;
    f_next.rf2 = f_reg.rf1;
    f_next.st1 = s_reg.fl;
    f_next.st2 = f_reg.st1;
    case (f_reg.phase)
      sfc_pkg::PH_CMD:
      begin
        f_next.crc = sfc_crc_step(f_reg.crc, sdi_i); // RULE18
        if (f_reg.bc < sfc_pkg::CNT_FIRST)
        begin
          f_next.cmd = {f_reg.cmd[6:0], sdi_i};
        end
        else
        begin
          f_next.cntb = {f_reg.cntb[6:0], sdi_i};
        end
        if (f_reg.bc == sfc_pkg::STAT_FIRST)
        begin
          cur = {f_reg.st2, 16'h0000}; // RULE8
        end
        if (ctrl_i[sfc_pkg::CTRL_STAT])
        begin
          f_next.sdo = cur[23]; // RULE8
        end
        f_next.sh = {cur[22:0], 1'b0};
        f_next.bc = f_reg.bc + 5'h01;
        if (f_reg.bc == sfc_pkg::CMD_LAST)
        begin
          f_next.bc = 5'h00;
          f_next.fst = 1'b1;
          f_next.phase = (f_reg.cmd == sfc_pkg::RD_CMD) ? sfc_pkg::PH_DATA : sfc_pkg::PH_IDLE;
        end
      end
      sfc_pkg::PH_DATA:
      begin
        // the last count bit arrives on the edge that sends the first data bit
        if (f_reg.fst)
        begin
          cr = sfc_crc_step(cr, sdi_i); // RULE18
          f_next.cntb = {f_reg.cntb[6:0], sdi_i};
          f_next.fst = 1'b0;
        end
        if (f_reg.bc == 5'h00)
        begin
          cur = wd;
        end
        f_next.sdo = cur[23]; // RULE26
        f_next.sh = {cur[22:0], 1'b0};
        f_next.crc = sfc_crc_step(cr, cur[23]); // RULE19 RULE26
        f_next.bc = f_reg.bc + 5'h01;
        if (f_reg.bc == len) // RULE24
        begin
          f_next.bc = 5'h00;
          f_next.idx = f_reg.idx + 9'h001;
          f_next.blk = f_reg.blk + 9'h001;
          pop = ~f_reg.rf2 & (f_reg.idx < s_reg.cnt);
          if (crc_on && f_next.blk == trig) // RULE17
          begin
            f_next.phase = sfc_pkg::PH_CRC;
            f_next.blk = 9'h000;
            f_next.sh = {f_next.crc, 8'h00};
            f_next.crc = sfc_pkg::CRC_INIT; // RULE18
          end
          else if (f_next.idx == nsmp)
          begin
            f_next.phase = sfc_pkg::PH_IDLE;
          end
        end
      end
      sfc_pkg::PH_CRC:
      begin
        f_next.sdo = f_reg.sh[23]; // RULE26
        f_next.sh = {f_reg.sh[22:0], 1'b0};
        f_next.bc = f_reg.bc + 5'h01;
        if (f_reg.bc == sfc_pkg::CRC_LAST)
        begin
          f_next.bc = 5'h00;
          f_next.phase = (f_reg.idx == nsmp) ? sfc_pkg::PH_IDLE : sfc_pkg::PH_DATA;
        end
      end
      default:
      begin
        f_next.sdo = 1'b0;
      end
    endcase
    p_next = p_reg;
    if (pop)
    begin
      p_next.pb = p_reg.pb + 9'h001;
      p_next.pg = p_next.pb ^ {1'b0, p_next.pb[8:1]};
    end
  end

  always_ff @(posedge sclk_i or negedge frm_rst_n)
  begin
    if (!frm_rst_n)
    begin
      f_reg <= '0;
      f_reg.crc <= sfc_pkg::CRC_INIT; // RULE19
    end
    else
    begin
      f_reg <= f_next;
    end
  end

  // consumed-sample count survives the frame; it reaches the master side gray coded
  always_ff @(posedge sclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      p_reg <= '0;
    end
    else
    begin
      p_reg <= p_next;
    end
  end

  assign sdo_o = f_reg.sdo;

endmodule : sfc_core

// ### dv/sfc_host.sv
// host side model that reads the sample buffer over the serial link
`timescale 1ns/1ps
module sfc_host (
  // serial link
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  logic rx [0:1023];
  logic [15:0] cmd_word;
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    cmd_word = 16'h0000;
  end
  // link clock stands still low outside frames
  task automatic frame(input logic [7:0] cmd, input logic [7:0] n, input int edges,
    input int hold_ns);
    cmd_word = {cmd, n};
    #17.3;
    cs_n_o = 1'b0;
    // kept above four master cycles so the lock has settled before the first edge
    #450;
    for (int k = 0; k < edges; k++)
    begin
      sdi_o = (k < 16) ? cmd_word[15 - k] : ~sdi_o;
      #3;
      sclk_o = 1'b1;
      #3;
      sclk_o = 1'b0;
      rx[k] = sdo_i;
    end
    #(hold_ns);
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #500;
  endtask : frame
  // checker crc over stream positions a..b: 0..15 are the command bits,
  // position i above that is received bit i-1, since data starts on edge 15
  function automatic logic [15:0] crc_over(input int a, input int b);
    logic [15:0] c;
    logic fb;
    c = sfc_pkg::CRC_INIT;
    for (int i = a; i <= b; i++)
    begin
      fb = c[15] ^ ((i < 16) ? cmd_word[15 - i] : rx[i - 1]);
      c = {c[14:0], 1'b0};
      if (fb)
        c = c ^ sfc_pkg::CRC_POLY;
    end
    return c;
  endfunction : crc_over
endmodule : sfc_host

// ### dv/sample_fifo_flags_crc_irq_tb.sv
// self-checking bench for the sample buffer flag, tag and crc block
`timescale 1ns/1ps
module sample_fifo_flags_crc_irq_tb;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [23:0] ctrl_i = sfc_pkg::CTRL_RST;
  logic ctrl_wr_i = 1'b0;
  logic ctrl_err_i = 1'b0;
  logic crc_en_i = 1'b0;
  logic [15:0] per_input_limit_enable_i = 16'h0004;
  logic [15:0] upper_limit_value_i = 16'h8000;
  logic [15:0] lower_limit_value_i = 16'h0100;
  logic conv_valid_i = 1'b0;
  logic [15:0] conv_data_i = 16'h0000;
  logic [3:0] source_input_index_i = 4'h0;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo_o;
  logic busy_o;
  logic [7:0] flags;
  logic fifo_int_o;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #50 clk_i = ~clk_i;

  sfc_core dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ctrl_i(ctrl_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_err_i(ctrl_err_i), .crc_en_i(crc_en_i),
    .per_input_limit_enable_i(per_input_limit_enable_i),
    .upper_limit_value_i(upper_limit_value_i), .lower_limit_value_i(lower_limit_value_i),
    .conv_valid_i(conv_valid_i), .conv_data_i(conv_data_i),
    .source_input_index_i(source_input_index_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdi_i(sdi), .sdo_o(sdo_o), .busy_o(busy_o), .buffer_condition_flags_o(flags),
    .fifo_int_o(fifo_int_o)
  );

  sfc_host host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_o));

  task automatic print_verdict();
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // generous ceiling: the whole sequence needs well under two thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic conv(input logic [15:0] d, input logic [3:0] idx);
    @(posedge clk_i);
    conv_valid_i <= 1'b1;
    conv_data_i <= d;
    source_input_index_i <= idx;
    @(posedge clk_i);
    conv_valid_i <= 1'b0;
  endtask : conv

  task automatic wrctrl(input logic [23:0] v);
    @(posedge clk_i);
    ctrl_i <= v;
    ctrl_wr_i <= 1'b1;
    @(posedge clk_i);
    ctrl_wr_i <= 1'b0;
  endtask : wrctrl

  // received bits pos..pos+w-1, first received in the msb
  function automatic logic [23:0] get(input int pos, input int w);
    logic [23:0] v;
    v = 24'h000000;
    for (int i = 0; i < w; i++)
      v = {v[22:0], host.rx[pos + i]};
    return v;
  endfunction : get

  initial
  begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    settle(1);
    check(24'(flags), 24'(sfc_pkg::FLAGS_RST));
    check(24'(fifo_int_o), 24'h000000);
    // watermark mode, watermark 4, tag on, watermark interrupt only
    wrctrl(24'h050204);
    conv(16'h9000, 4'h2);
    conv(16'h0050, 4'h2);
    conv(16'h1234, 4'h3);
    settle(1);
    check(24'({busy_o, flags[1]}), 24'h000002);
    conv(16'h9000, 4'h3);
    settle(1);
    check(24'({busy_o, fifo_int_o, flags}), 24'h00011A);
    conv(16'h7777, 4'h1);
    settle(1);
    check(24'(flags), 24'h00005E);
    host.frame(sfc_pkg::RD_CMD, 8'h04, 112, 0);
    check(get(15, 24), 24'h900042);
    check(get(39, 24), 24'h005042);
    check(get(63, 24), 24'h123403);
    check(get(87, 24), 24'h900033);
    settle(4);
    check(24'({busy_o, fifo_int_o, flags}), 24'h000201);
    // status append, tag off; the control write must clear what is stored
    conv(16'h4444, 4'h0);
    settle(1);
    check(24'(flags[0]), 24'h000000);
    wrctrl(24'h090002);
    settle(1);
    check(24'(flags), 24'h000001);
    conv(16'h0A0A, 4'h1);
    conv(16'h8001, 4'h5);
    settle(1);
    check(24'(flags), 24'h000012);
    host.frame(sfc_pkg::RD_CMD, 8'h02, 48, 0);
    check(get(7, 8), 24'h000012);
    check(get(15, 16), 24'h000A0A);
    check(get(31, 16), 24'h008001);
    @(posedge clk_i);
    ctrl_err_i <= 1'b1;
    settle(2);
    check(24'(flags[7]), 24'h000001);
    @(posedge clk_i);
    ctrl_err_i <= 1'b0;
    // streaming, tag on, watermark 2, crc on
    wrctrl(24'h060002);
    @(posedge clk_i);
    crc_en_i <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      conv(16'h1111 * 16'(i + 1), 4'(i));
      // busy stands only one cycle after each stored write in streaming
      #1;
      check(24'(busy_o), 24'h000001);
    end
    host.frame(sfc_pkg::RD_CMD, 8'h04, 144, 0);
    check(get(63, 16), 24'(host.crc_over(0, 63)));
    check(get(79, 24), 24'h333322);
    check(get(127, 16), 24'(host.crc_over(80, 127)));
    @(posedge clk_i);
    crc_en_i <= 1'b0;
    // a write held through a long readback, then a second one, loses a result
    wrctrl(24'h050000);
    conv(16'h0101, 4'h1);
    conv(16'h0202, 4'h1);
    fork
      host.frame(sfc_pkg::RD_CMD, 8'h01, 40, 2500);
      begin
        settle(10);
        conv(16'h0303, 4'h1);
        conv(16'h0404, 4'h1);
      end
    join
    settle(4);
    check(24'(flags[6]), 24'h000001);
    // a result offered on the cycle the frame is taken refuses that read
    fork
      host.frame(sfc_pkg::RD_CMD, 8'h01, 40, 0);
      begin
        @(posedge clk_i);
        conv(16'h0505, 4'h1);
      end
    join
    check(get(15, 24), 24'h000000);
    settle(4);
    check(24'(flags[5]), 24'h000001);
    // the next granted read returns the oldest sample and clears the error
    host.frame(sfc_pkg::RD_CMD, 8'h01, 40, 0);
    check(get(15, 24), 24'h020201);
    settle(4);
    check(24'(flags[5]), 24'h000000);
    // streaming with watermark field 0: trigger at 256, overrun past full
    wrctrl(24'h060200);
    repeat (255) conv(16'h0200, 4'h1);
    settle(1);
    check(24'(fifo_int_o), 24'h000000);
    conv(16'h0200, 4'h1);
    settle(1);
    check(24'({fifo_int_o, flags[2]}), 24'h000002);
    conv(16'h0200, 4'h1);
    settle(1);
    check(24'(flags[2]), 24'h000001);
    print_verdict();
  end
endmodule : sample_fifo_flags_crc_irq_tb
